/* src/afsp_pkg.sv */
/*
  Shared constants and types of the framed serial port of the converter.
  Assumes a 100 MHz system clock and a serial clock of its own on the link.
*/
package afsp_pkg;

  // System clock
  localparam int MCLK_PERIOD_NS = 10;

  // Conversion time, rounded up to whole cycles
  localparam int CONV_TIME_NS = 5900;
  localparam int CONV_CYCLES = (CONV_TIME_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;
  localparam int CONV_CNT_W = 10;

  // Read word framing
  localparam int RESULT_BITS = 12;
  localparam int CHAN_BITS = 3;
  localparam int WORD_BITS = 16;
  localparam logic [4:0] WORD_FALLS = 5'h10;
  localparam logic [3:0] WORD_MSB = 4'hF;
  localparam logic [3:0] LAST_RISE = 4'hF;

  // Write framing: five data bits, load on the sixth falling edge
  localparam int CTRL_BITS = 5;
  localparam logic [2:0] CTRL_DATA_FALLS = 3'h5;
  localparam logic [2:0] CTRL_LOAD_DONE = 3'h6;

  // Control register field positions, first bit received is bit 4
  localparam int CTRL_CHAN_HI = 4;
  localparam int CTRL_CHAN_LO = 2;
  localparam int CTRL_SW_START = 1;
  localparam int CTRL_STANDBY = 0;
  localparam logic [CTRL_BITS-1:0] CTRL_RESET = 5'h00;

  // Synchroniser lanes into the system clock domain
  localparam int SY_ROLE = 0;
  localparam int SY_CONVERSION_START_STROBE = 1;
  localparam int SY_WFS = 2;
  localparam int SY_RFS = 3;
  localparam int SY_WTOG = 4;
  localparam int SY_W = 5;
  localparam logic [SY_W-1:0] SY_RESET = 5'h0D;

  typedef struct packed {
    logic [CHAN_BITS-1:0] chan;
    logic sw_start;
    logic standby;
  } afsp_ctrl_t;

  typedef struct packed {
    logic lead_zero;
    logic [CHAN_BITS-1:0] chan;
    logic [RESULT_BITS-1:0] result;
  } afsp_word_t;

  // Self-clocking generator, Gray coded along idle, high, low
  typedef enum logic [1:0] {
    GEN_IDLE = 2'b00,
    GEN_HIGH = 2'b01,
    GEN_LOW = 2'b11
  } afsp_gen_state_t;

endpackage : afsp_pkg

/* src/afsp_port.sv */
/*
  Framed serial port of an eight-channel 12-bit converter: read shifter,
  control write capture, self-clocking generator, delay pulse and
  conversion timing. Assumes the bench resolves the two-way SCLK and read
  frame sync wires (pull-up on SCLK) and feeds the resolved levels back on
  the _I ports, so the link logic runs on the wire clock in both roles.
*/
// Functional notes
// - Reads shift the output word out; writes load the control register.
// - Role strap low: device makes serial clock and read frame sync.
// - Role strap high: serial clock and read frame sync are host inputs.
// - Word: zero, three channel bits, twelve result bits, MSB first.
// - Self-clocking: conversion end drops read sync and starts clock and data.
// - Data changes on rising serial clock, sampled on falling edge.
// - Self-clocking: sync low sixteen cycles, high and data released at 16th rise.
// - Self-clocking: write sync falling starts serial clock pulses.
// - Write captures first five bits only; later bits ignored.
// - External clock may stop; word may be fetched in bytes.
// - Sync falling drives zero at once, whether clock is high or low.
// - Data released on first rising edge of clock or read sync after read.
// - Output word update deferred while a read is in progress.
// - Tied syncs: read and write share one frame.
// - Software start takes effect at sixth edge; read runs ten more cycles.
// - Each write starts delay pulse; timeout from sixth fall; starts wait for it.
// - Start strobe rising begins conversion; result ready 5.9 us later.
`timescale 1ns/1ps
module afsp_port #(
  parameter int SCLK_HALF_CYCLES = 20,
  parameter int DELAY_PULSE_NS = 2000
) (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SERIAL_ROLE_SELECT,
  input wire logic CONVERSION_START_STROBE,
  input wire logic SCLK_I,
  output logic SCLK_O,
  output logic SCLK_OE_N,
  input wire logic READ_FRAME_SYNC_I,
  output logic READ_FRAME_SYNC_O,
  output logic READ_FRAME_SYNC_OE_N,
  input wire logic WRITE_FRAME_SYNC,
  input wire logic DATA_IN,
  output logic DATA_OUT_O,
  output logic DATA_OUT_OE_N,
  input wire logic [afsp_pkg::RESULT_BITS-1:0] ADC_CODE,
  output logic [afsp_pkg::CHAN_BITS-1:0] CHANNEL_SEL,
  output logic STANDBY,
  output logic TRACK_HOLD,
  output logic DELAY_PULSE
);

  localparam int DELAY_CYCLES =
    (DELAY_PULSE_NS + afsp_pkg::MCLK_PERIOD_NS - 1) / afsp_pkg::MCLK_PERIOD_NS;
  localparam int DLY_W = 20;
  localparam int DIV_W = 8;
  localparam logic [DLY_W-1:0] DLY_LOAD = DLY_W'(DELAY_CYCLES);
  localparam logic [DLY_W-1:0] DLY_ONE = 20'h00001;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCLK_HALF_CYCLES - 1);
  localparam logic [afsp_pkg::CONV_CNT_W-1:0] CONV_LOAD =
    afsp_pkg::CONV_CNT_W'(afsp_pkg::CONV_CYCLES);
  localparam logic [afsp_pkg::CONV_CNT_W-1:0] CONV_ONE = 10'h001;

  if (SCLK_HALF_CYCLES < 1 || SCLK_HALF_CYCLES > 256) begin : g_chk_div
    $error("SCLK_HALF_CYCLES out of range");
  end
  if (DELAY_CYCLES < 1 || DELAY_CYCLES >= (1 << DLY_W)) begin : g_chk_dly
    $error("DELAY_PULSE_NS out of range");
  end

  function automatic logic word_bit(input afsp_pkg::afsp_word_t w, input logic [4:0] falls);
    logic [3:0] idx;
    idx = afsp_pkg::WORD_MSB - falls[3:0];
    word_bit = (falls >= afsp_pkg::WORD_FALLS) ? 1'b0 : w[idx];
  endfunction : word_bit

  // System domain state read by the link
  afsp_pkg::afsp_word_t out_word_reg;

  // Link domain: read shifter
  logic [4:0] rd_falls_reg;
  logic rd_data_reg;
  logic rd_done_reg;

  always_ff @(negedge SCLK_I or posedge READ_FRAME_SYNC_I) begin
    if (READ_FRAME_SYNC_I) begin
      rd_falls_reg <= 5'h00;
    end else if (rd_falls_reg != afsp_pkg::WORD_FALLS) begin
      rd_falls_reg <= rd_falls_reg + 5'h01;
    end
  end

  // Idle value zero doubles as the leading zero on a sync fall in clock high
  always_ff @(posedge SCLK_I or posedge READ_FRAME_SYNC_I) begin
    if (READ_FRAME_SYNC_I) begin
      rd_data_reg <= 1'b0;
    end else begin
      rd_data_reg <= word_bit(out_word_reg, rd_falls_reg);
    end
  end

  always_ff @(posedge SCLK_I or posedge READ_FRAME_SYNC_I) begin
    if (READ_FRAME_SYNC_I) begin
      rd_done_reg <= 1'b0;
    end else if (rd_falls_reg == afsp_pkg::WORD_FALLS) begin
      rd_done_reg <= 1'b1;
    end
  end

  assign DATA_OUT_O = rd_data_reg;
  assign DATA_OUT_OE_N = READ_FRAME_SYNC_I | rd_done_reg;

  // Link domain: control write capture
  logic [2:0] wr_falls_reg;
  logic [afsp_pkg::CTRL_BITS-1:0] wr_shift_reg;
  logic [afsp_pkg::CTRL_BITS-1:0] ctrl_link_reg;
  logic wr_tog_reg;

  always_ff @(negedge SCLK_I or posedge WRITE_FRAME_SYNC) begin
    if (WRITE_FRAME_SYNC) begin
      wr_falls_reg <= 3'h0;
      wr_shift_reg <= afsp_pkg::CTRL_RESET;
    end else if (wr_falls_reg != afsp_pkg::CTRL_LOAD_DONE) begin
      wr_falls_reg <= wr_falls_reg + 3'h1;
      if (wr_falls_reg < afsp_pkg::CTRL_DATA_FALLS) begin
        wr_shift_reg <= {wr_shift_reg[afsp_pkg::CTRL_BITS-2:0], DATA_IN};
      end
    end
  end

  always_ff @(negedge SCLK_I or posedge RST) begin
    if (RST) begin
      ctrl_link_reg <= afsp_pkg::CTRL_RESET;
      wr_tog_reg <= 1'b0;
    end else if (!WRITE_FRAME_SYNC && wr_falls_reg == afsp_pkg::CTRL_DATA_FALLS) begin
      ctrl_link_reg <= wr_shift_reg;
      wr_tog_reg <= ~wr_tog_reg;
    end
  end

  // System domain synchronisers
  logic [afsp_pkg::SY_W-1:0] sy1_reg;
  logic [afsp_pkg::SY_W-1:0] sy2_reg;
  logic [afsp_pkg::SY_W-1:0] sy3_reg;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sy1_reg <= afsp_pkg::SY_RESET;
      sy2_reg <= afsp_pkg::SY_RESET;
      sy3_reg <= afsp_pkg::SY_RESET;
    end else begin
      sy1_reg <= {wr_tog_reg, READ_FRAME_SYNC_I, WRITE_FRAME_SYNC,
                  CONVERSION_START_STROBE, SERIAL_ROLE_SELECT};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
    end
  end

  logic wfs_fall;
  logic ctrl_load;
  logic hw_start;
  logic master_reg;

  assign wfs_fall = !sy2_reg[afsp_pkg::SY_WFS] && sy3_reg[afsp_pkg::SY_WFS];
  assign ctrl_load = sy2_reg[afsp_pkg::SY_WTOG] ^ sy3_reg[afsp_pkg::SY_WTOG];
  assign hw_start = sy2_reg[afsp_pkg::SY_CONVERSION_START_STROBE] && !sy3_reg[afsp_pkg::SY_CONVERSION_START_STROBE];

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      master_reg <= 1'b0;
    end else begin
      master_reg <= !sy2_reg[afsp_pkg::SY_ROLE];
    end
  end

  // Control register, word stable in the link for six edges after the toggle
  afsp_pkg::afsp_ctrl_t ctrl_reg;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      ctrl_reg <= afsp_pkg::CTRL_RESET;
    end else if (ctrl_load) begin
      ctrl_reg <= ctrl_link_reg;
    end
  end

  assign CHANNEL_SEL = ctrl_reg.chan;
  assign STANDBY = ctrl_reg.standby;

  // Internal delay pulse
  logic dly_active_reg;
  logic dly_timing_reg;
  logic [DLY_W-1:0] dly_cnt_reg;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      dly_active_reg <= 1'b0;
      dly_timing_reg <= 1'b0;
      dly_cnt_reg <= '0;
    end else if (ctrl_load) begin
      dly_active_reg <= 1'b1;
      dly_timing_reg <= 1'b1;
      dly_cnt_reg <= DLY_LOAD;
    end else if (wfs_fall) begin
      dly_active_reg <= 1'b1;
      dly_timing_reg <= 1'b0;
    end else if (dly_timing_reg) begin
      dly_cnt_reg <= dly_cnt_reg - DLY_ONE;
      if (dly_cnt_reg == DLY_ONE) begin
        dly_active_reg <= 1'b0;
        dly_timing_reg <= 1'b0;
      end
    end
  end

  assign DELAY_PULSE = dly_active_reg;

  // Conversion timing
  logic start_pend_reg;
  logic conv_busy_reg;
  logic [afsp_pkg::CONV_CNT_W-1:0] conv_cnt_reg;
  logic [afsp_pkg::RESULT_BITS-1:0] sample_reg;
  logic conv_begin;
  logic conv_end;
  logic start_event;

  assign start_event = hw_start || (ctrl_load && ctrl_link_reg[afsp_pkg::CTRL_SW_START]);
  assign conv_begin = start_pend_reg && !dly_active_reg && !conv_busy_reg;
  assign conv_end = conv_busy_reg && conv_cnt_reg == CONV_ONE;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      start_pend_reg <= 1'b0;
    end else begin
      start_pend_reg <= (start_pend_reg && !conv_begin) || start_event;
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      conv_busy_reg <= 1'b0;
      conv_cnt_reg <= '0;
      sample_reg <= '0;
    end else if (conv_begin) begin
      conv_busy_reg <= 1'b1;
      conv_cnt_reg <= CONV_LOAD;
      sample_reg <= ADC_CODE;
    end else if (conv_busy_reg) begin
      conv_cnt_reg <= conv_cnt_reg - CONV_ONE;
      if (conv_end) begin
        conv_busy_reg <= 1'b0;
      end
    end
  end

  assign TRACK_HOLD = conv_busy_reg;

  // Output word update, held off while any read frame is open
  afsp_pkg::afsp_gen_state_t gen_state_reg;
  logic res_pend_reg;
  logic [afsp_pkg::RESULT_BITS-1:0] res_data_reg;
  logic read_req_reg;
  logic read_busy;
  logic word_update;
  logic gen_start;

  assign read_busy = master_reg ? (gen_state_reg != afsp_pkg::GEN_IDLE || read_req_reg)
                                : !sy2_reg[afsp_pkg::SY_RFS];
  assign word_update = res_pend_reg && !read_busy;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      res_pend_reg <= 1'b0;
      res_data_reg <= '0;
    end else begin
      res_pend_reg <= (res_pend_reg && !word_update) || conv_end;
      if (conv_end) begin
        res_data_reg <= sample_reg;
      end
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      out_word_reg <= '0;
    end else if (word_update) begin
      out_word_reg <= {1'b0, ctrl_reg.chan, res_data_reg};
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      read_req_reg <= 1'b0;
    end else if (word_update && master_reg) begin
      read_req_reg <= 1'b1;
    end else if (gen_start) begin
      read_req_reg <= 1'b0;
    end
  end

  // Self-clocking generator; clock starts high so the sync edge leads
  logic [DIV_W-1:0] div_cnt_reg;
  logic [3:0] rise_cnt_reg;
  logic gen_rfs_reg;
  logic gen_sclk_reg;
  logic half_done;

  assign gen_start = master_reg && gen_state_reg == afsp_pkg::GEN_IDLE &&
                     (read_req_reg || wfs_fall);
  assign half_done = div_cnt_reg == DIV_LAST;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      gen_state_reg <= afsp_pkg::GEN_IDLE;
      div_cnt_reg <= '0;
      rise_cnt_reg <= 4'h0;
      gen_rfs_reg <= 1'b1;
      gen_sclk_reg <= 1'b1;
    end else begin
      case (gen_state_reg)
        afsp_pkg::GEN_IDLE: begin
          div_cnt_reg <= '0;
          rise_cnt_reg <= 4'h0;
          gen_sclk_reg <= 1'b1;
          if (gen_start) begin
            gen_state_reg <= afsp_pkg::GEN_HIGH;
            gen_rfs_reg <= !read_req_reg;
          end
        end
        afsp_pkg::GEN_HIGH: begin
          div_cnt_reg <= half_done ? '0 : div_cnt_reg + DIV_W'(1);
          if (half_done) begin
            gen_state_reg <= afsp_pkg::GEN_LOW;
            gen_sclk_reg <= 1'b0;
          end
        end
        afsp_pkg::GEN_LOW: begin
          div_cnt_reg <= half_done ? '0 : div_cnt_reg + DIV_W'(1);
          if (half_done) begin
            gen_sclk_reg <= 1'b1;
            rise_cnt_reg <= rise_cnt_reg + 4'h1;
            if (rise_cnt_reg == afsp_pkg::LAST_RISE) begin
              gen_state_reg <= afsp_pkg::GEN_IDLE;
              gen_rfs_reg <= 1'b1;
            end else begin
              gen_state_reg <= afsp_pkg::GEN_HIGH;
            end
          end
        end
        default: begin
          gen_state_reg <= afsp_pkg::GEN_IDLE;
          gen_rfs_reg <= 1'b1;
          gen_sclk_reg <= 1'b1;
        end
      endcase
    end
  end

  assign SCLK_O = gen_sclk_reg;
  assign SCLK_OE_N = !master_reg;
  assign READ_FRAME_SYNC_O = gen_rfs_reg;
  assign READ_FRAME_SYNC_OE_N = !master_reg;

endmodule : afsp_port

/* testbench/afsp_port_checker.sv */
/* Concurrent checks on the framed serial port ports.
   Bound to afsp_port from the bench top; sees ports only. */
`timescale 1ns/1ps
module afsp_port_checker (
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SERIAL_ROLE_SELECT,
  input wire logic CONVERSION_START_STROBE,
  input wire logic SCLK_O,
  input wire logic SCLK_OE_N,
  input wire logic READ_FRAME_SYNC_I,
  input wire logic READ_FRAME_SYNC_O,
  input wire logic READ_FRAME_SYNC_OE_N,
  input wire logic WRITE_FRAME_SYNC,
  input wire logic DATA_OUT_OE_N,
  input wire logic [afsp_pkg::CHAN_BITS-1:0] CHANNEL_SEL,
  input wire logic STANDBY,
  input wire logic TRACK_HOLD,
  input wire logic DELAY_PULSE
);
  logic [9:0] th_cnt_reg;
  logic [4:0] fall_cnt_reg;
  logic sclk_reg;
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // Length of the hold phase
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) th_cnt_reg <= 10'h000;
    else if (!TRACK_HOLD) th_cnt_reg <= 10'h000;
    else th_cnt_reg <= th_cnt_reg + 10'h001;
  end
  // Generated clock falls inside a read frame
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sclk_reg <= 1'b1;
      fall_cnt_reg <= 5'h00;
    end else begin
      sclk_reg <= SCLK_O;
      if (READ_FRAME_SYNC_O) fall_cnt_reg <= 5'h00;
      else if (sclk_reg && !SCLK_O) fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end
  end
  chk_slave_role: assert property (
    SERIAL_ROLE_SELECT && $past(SERIAL_ROLE_SELECT, 4) |-> SCLK_OE_N && READ_FRAME_SYNC_OE_N)
    else $error("slave role drives a clock or sync");
  chk_data_idle: assert property (READ_FRAME_SYNC_I |-> DATA_OUT_OE_N)
    else $error("data driven outside frame");
  chk_frame_len: assert property ($rose(READ_FRAME_SYNC_O) |-> fall_cnt_reg == 5'h10)
    else $error("read frame not sixteen clocks");
  chk_read_start: assert property ($fell(READ_FRAME_SYNC_O) |->
    SCLK_O && !SCLK_OE_N && !DATA_OUT_OE_N) else $error("read frame start wrong");
  chk_conv_len: assert property (
    $fell(TRACK_HOLD) |-> th_cnt_reg == 10'(afsp_pkg::CONV_CYCLES))
    else $error("conversion length wrong");
  chk_start_gate: assert property ($rose(TRACK_HOLD) |-> !DELAY_PULSE)
    else $error("conversion began inside delay");
  chk_hw_start: assert property ($rose(CONVERSION_START_STROBE) && !DELAY_PULSE
    && !TRACK_HOLD |-> ##[1:6] TRACK_HOLD) else $error("start strobe ignored");
  chk_delay_rise: assert property ($fell(WRITE_FRAME_SYNC) |-> ##[1:6] DELAY_PULSE)
    else $error("delay pulse missing");
  chk_ctrl_update: assert property (
    $changed({CHANNEL_SEL, STANDBY}) |-> DELAY_PULSE) else $error("control changed idle");
  cover property ($fell(TRACK_HOLD));
  cover property ($rose(READ_FRAME_SYNC_O));
  cover property ($changed(CHANNEL_SEL));
endmodule : afsp_port_checker

/* testbench/afsp_host.sv */
/* Host serial port model: clocks slave frames, follows master frames.
   Resolves the shared clock, sync and data wires for the bench. */
`timescale 1ns/1ps
module afsp_host (
  input wire logic sclk_o,
  input wire logic sclk_oe_n,
  input wire logic rfs_o,
  input wire logic rfs_oe_n,
  input wire logic dout_o,
  input wire logic dout_oe_n,
  output logic sclk_w,
  output logic rfs_w,
  output logic wfs,
  output logic din,
  output logic dout_w
);
  logic hclk = 1'b1;
  logic hrfs = 1'b1;
  logic last_d = 1'b0;
  initial begin
    wfs = 1'b1;
    din = 1'b0;
  end
  // Pull-up: host clock rests high outside frames
  assign sclk_w = sclk_oe_n ? hclk : sclk_o;
  assign rfs_w = rfs_oe_n ? hrfs : rfs_o;
  // Released data shows the inverse of its last level
  always @* if (!dout_oe_n) last_d = dout_o;
  assign dout_w = dout_oe_n ? ~last_d : dout_o;
  // Slave frame, 6 ns clock; gap stalls the clock high after eight bits
  task automatic xfer(input logic [15:0] wr, input int n, input bit rd_en, input bit wr_en,
                      input bit low, input int gap, output logic [15:0] rd);
    rd = 16'h0000;
    din = wr[15];
    #2.3;
    if (low) hclk = 1'b0;
    #2;
    hrfs = ~rd_en;
    wfs = ~wr_en;
    #2;
    if (low) hclk = 1'b1;
    #3;
    for (int i = 0; i < n; i++) begin
      hclk = 1'b0;
      rd = {rd[14:0], dout_w};
      #3 hclk = 1'b1;
      din = (i < 15) ? wr[14 - i] : 1'b0;
      #((i == 7) ? gap : 3);
    end
    hrfs = 1'b1;
    wfs = 1'b1;
  endtask : xfer
  // Frame clocked by the device; write opens it, else wait for its sync
  task automatic mxfer(input logic [15:0] wr, input bit wr_en, output logic [15:0] rd);
    rd = 16'h0000;
    din = wr[15];
    if (wr_en) wfs = 1'b0;
    else @(negedge rfs_w);
    for (int i = 0; i < 16; i++) begin
      @(negedge sclk_w) rd = {rd[14:0], dout_w};
      @(posedge sclk_w) din = (i < 15) ? wr[14 - i] : 1'b0;
    end
    wfs = 1'b1;
  endtask : mxfer
endmodule : afsp_host

/* testbench/afsp_port_tb.sv */
/* Bench top of the framed serial port: host model, scenarios, verdict.
   Assumes the checker and host model are compiled before it. */
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module afsp_port_tb;
  logic mclk, rst, role, strobe, stby, th, dly;
  logic sclk_o, sclk_oe_n, rfs_o, rfs_oe_n, dout_o, dout_oe_n, sclk_w, rfs_w, wfs, din, dout_w;
  logic [11:0] code;
  logic [2:0] chan;
  logic [15:0] rd;
  int n_errors = 0;
  int checks = 0;
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  afsp_port #(.SCLK_HALF_CYCLES(2), .DELAY_PULSE_NS(50)) dut (
    .MCLK(mclk), .RST(rst), .SERIAL_ROLE_SELECT(role), .CONVERSION_START_STROBE(strobe),
    .SCLK_I(sclk_w), .SCLK_O(sclk_o), .SCLK_OE_N(sclk_oe_n), .READ_FRAME_SYNC_I(rfs_w),
    .READ_FRAME_SYNC_O(rfs_o), .READ_FRAME_SYNC_OE_N(rfs_oe_n), .WRITE_FRAME_SYNC(wfs),
    .DATA_IN(din), .DATA_OUT_O(dout_o), .DATA_OUT_OE_N(dout_oe_n), .ADC_CODE(code),
    .CHANNEL_SEL(chan), .STANDBY(stby), .TRACK_HOLD(th), .DELAY_PULSE(dly));
  afsp_host host (.sclk_o(sclk_o), .sclk_oe_n(sclk_oe_n), .rfs_o(rfs_o), .rfs_oe_n(rfs_oe_n),
    .dout_o(dout_o), .dout_oe_n(dout_oe_n), .sclk_w(sclk_w), .rfs_w(rfs_w), .wfs(wfs),
    .din(din), .dout_w(dout_w));
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  task automatic hw_start(input logic [11:0] c);
    code = c;
    strobe = 1'b1;
    tick(7);
    `CHK("tracking", 1'b1, th)
    strobe = 1'b0;
  endtask : hw_start
  task automatic t_write;
    // Short frame first: it leaves the delay pulse up until a full write
    host.xfer(16'hF800, 5, 1'b0, 1'b1, 1'b0, 3, rd);
    tick(12);
    `CHK("short write", 3'h0, chan)
    host.xfer(16'hAFFF, 8, 1'b0, 1'b1, 1'b0, 3, rd);
    tick(12);
    `CHK("channel", 3'h5, chan)
    `CHK("standby", 1'b1, stby)
    $display("write test done");
  endtask : t_write
  task automatic t_hw_read;
    hw_start(12'hA5C);
    tick(600);
    `CHK("converted", 1'b0, th)
    host.xfer(16'h0000, 16, 1'b1, 1'b0, 1'b0, 40, rd);
    `CHK("word high start", 16'h5A5C, rd)
    host.xfer(16'h0000, 16, 1'b1, 1'b0, 1'b1, 3, rd);
    `CHK("word low start", 16'h5A5C, rd)
    tick(1);
    `CHK("released", 1'b1, dout_oe_n)
    $display("read test done");
  endtask : t_hw_read
  task automatic t_tied;
    code = 12'h3C1;
    host.xfer(16'h7000, 16, 1'b1, 1'b1, 1'b0, 40, rd);
    `CHK("old word", 16'h5A5C, rd)
    tick(620);
    `CHK("sw channel", 3'h3, chan)
    `CHK("sw standby", 1'b0, stby)
    host.xfer(16'h0000, 16, 1'b1, 1'b0, 1'b0, 3, rd);
    `CHK("sw word", 16'h33C1, rd)
    hw_start(12'h111);
    host.xfer(16'h0000, 16, 1'b1, 1'b0, 1'b0, 7000, rd);
    `CHK("held word", 16'h33C1, rd)
    // Sync must stay high long enough to be seen before the deferred update
    tick(6);
    host.xfer(16'h0000, 16, 1'b1, 1'b0, 1'b0, 3, rd);
    `CHK("late word", 16'h3111, rd)
    $display("tied test done");
  endtask : t_tied
  task automatic t_master;
    role = 1'b0;
    tick(8);
    `CHK("clock driven", 1'b0, sclk_oe_n)
    host.mxfer(16'h2000, 1'b1, rd);
    tick(12);
    `CHK("master channel", 3'h1, chan)
    hw_start(12'h0FF);
    host.mxfer(16'h0000, 1'b0, rd);
    `CHK("master word", 16'h10FF, rd)
    tick(2);
    `CHK("sync back", 1'b1, rfs_w)
    `CHK("data off", 1'b1, dout_oe_n)
    $display("master test done");
  endtask : t_master
  initial begin
    rst = 1'b1;
    role = 1'b1;
    strobe = 1'b0;
    code = 12'h000;
    tick(3);
    rst = 1'b0;
    tick(6);
    t_write;
    t_hw_read;
    t_tied;
    t_master;
    end_of_test;
  end
  initial begin
    #200000;
    n_errors++;
    end_of_test;
  end
endmodule : afsp_port_tb
bind afsp_port afsp_port_checker u_chk (.MCLK(MCLK), .RST(RST),
  .SERIAL_ROLE_SELECT(SERIAL_ROLE_SELECT), .CONVERSION_START_STROBE(CONVERSION_START_STROBE),
  .SCLK_O(SCLK_O), .SCLK_OE_N(SCLK_OE_N), .READ_FRAME_SYNC_I(READ_FRAME_SYNC_I),
  .READ_FRAME_SYNC_O(READ_FRAME_SYNC_O), .READ_FRAME_SYNC_OE_N(READ_FRAME_SYNC_OE_N),
  .WRITE_FRAME_SYNC(WRITE_FRAME_SYNC), .DATA_OUT_OE_N(DATA_OUT_OE_N),
  .CHANNEL_SEL(CHANNEL_SEL), .STANDBY(STANDBY), .TRACK_HOLD(TRACK_HOLD),
  .DELAY_PULSE(DELAY_PULSE));
